// *** src/wwd_top.sv ***
// window watchdog: trigger qualification, window sequencing, reset pulse generation
`timescale 1ns/100ps
`include "wwd_defines.svh"
module wwd_top
  import wwd_pkg::*;
#(
  parameter logic [17:0] RESET_CYC    = 18'(`WWD_RESET_CYC),
  parameter logic [8:0]  TRIG_MIN_CYC = 9'(`WWD_TRIG_MIN_CYC),
  parameter logic [12:0] LEAD_TICKS   = 13'(`WWD_LEAD_TICKS),
  parameter logic [12:0] CLOSED_TICKS = 13'(`WWD_CLOSED_TICKS),
  parameter logic [12:0] OPEN_TICKS   = 13'(`WWD_OPEN_TICKS),
  parameter logic [9:0]  FS_DIV       = 10'(`WWD_FS_DIV)
)(
  input  wire logic CLK,
  input  wire logic RST_B,
  input  wire logic WD_TRIGGER_N,
  input  wire logic WD_OSC_RESISTOR_PIN,
  input  wire logic OSC_FAULT,
  input  wire logic DIVIDER_STRAP_PIN,
  input  wire logic SLEEP_MODE,
  input  wire logic CFG_WORD_STB,
  input  wire logic CFG_WD_DISABLE,
  input  wire logic LP_REQUEST,
  output logic      RESET_OUT_N,
  output logic      WD_DISABLE_BIT,
  output logic      LOW_POWER_EN,
  output logic      WD_RUNNING
);

  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================
  // pin synchronisers
  logic [3:0] sync_meta;
  logic [3:0] sync_q;
  logic       osc_d;
  wire  [3:0] sync_in = {WD_TRIGGER_N, WD_OSC_RESISTOR_PIN, OSC_FAULT, DIVIDER_STRAP_PIN};
  wire        trig_s  = sync_q[3];
  wire        osc_s   = sync_q[2];
  wire        fault_s = sync_q[1];
  wire        strap_s = sync_q[0];

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // idle pin levels, so release brings no false trigger, tick, fault or strap
      sync_meta <= 4'hc;
      sync_q    <= 4'hc;
      osc_d     <= 1'b1;
    end
    else
    begin
      sync_meta <= sync_in;
      sync_q    <= sync_meta;
      osc_d     <= osc_s;
    end
  end

  // ==========================================================
  // tick source
  // one tick per rising edge of the synced square wave
  logic [9:0] fs_cnt;
  wire        fs_tick  = (fs_cnt == FS_DIV - 10'h001);
  wire        ext_tick = osc_s & ~osc_d;
  // resistor fault: internal oscillator keeps the windows running
  wire        tick     = fault_s ? fs_tick : ext_tick;

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      fs_cnt <= 10'h000;
    else
      fs_cnt <= fs_tick ? 10'h000 : fs_cnt + 10'h001;
  end

  // ==========================================================
  // trigger qualification
  // a trigger counts once the low phase has outlasted the glitch limit,
  // so its effect lags the falling edge by that limit
  logic [8:0] low_cnt;
  wire        low_sat    = (low_cnt == TRIG_MIN_CYC);
  wire        trig_valid = ~trig_s & (low_cnt == TRIG_MIN_CYC - 9'h001);
  // with a resistor fault no trigger is ever accepted, so resets keep coming
  wire        trig_ok    = trig_valid & ~fault_s;

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      low_cnt <= 9'h000;
    else if (trig_s)
      low_cnt <= 9'h000;
    else if (!low_sat)
      low_cnt <= low_cnt + 9'h001;
  end

  // ==========================================================
  // disable bit, strap and low-power gate
  // low-power permission follows the bit one cycle late
  logic cfg_pend;
  logic strap_dis;
  wire  wd_off = WD_DISABLE_BIT | strap_dis;

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_pend       <= 1'b0;
      WD_DISABLE_BIT <= 1'b0;
      LOW_POWER_EN   <= 1'b0;
    end
    else
    begin
      if (CFG_WORD_STB)
      begin
        cfg_pend <= CFG_WD_DISABLE;
        // clearing takes one word, setting needs two in a row
        WD_DISABLE_BIT <= CFG_WD_DISABLE & cfg_pend;
      end
      LOW_POWER_EN <= LP_REQUEST & WD_DISABLE_BIT;
    end
  end

  // ==========================================================
  // window sequencer
  wwd_state_type state;
  wwd_state_type next_state;
  logic [12:0]   tick_cnt;
  logic [17:0]   ms_cnt;
  wire           ms_done  = (ms_cnt == RESET_CYC - 18'h00001);
  wire           lead_end = tick & (tick_cnt == LEAD_TICKS - 13'h0001);
  wire           clo_end  = tick & (tick_cnt == CLOSED_TICKS - 13'h0001);
  wire           open_end = tick & (tick_cnt == OPEN_TICKS - 13'h0001);
  wire           st_chg   = (next_state != state);
  wire           next_low = (next_state == WWD_POR) | (next_state == WWD_RST);
  // timers run only in the states that use them, so sleep and off really stop counting
  wire           timing_st = (state == WWD_POR) | (state == WWD_RST);
  wire           count_st  = (state == WWD_LEAD) | (state == WWD_CLOSED) | (state == WWD_OPEN);

  always_comb
  begin
    next_state = state;
    // sleep wins over everything; a disable acts everywhere but in the startup hold
    if (SLEEP_MODE)
      next_state = WWD_OFF;
    else if (wd_off && state != WWD_POR)
      next_state = WWD_OFF;
    else
    begin
      case (state)
        WWD_POR:
          if (ms_done)
            next_state = strap_s ? WWD_OFF : WWD_LEAD;
        WWD_LEAD:
          if (trig_ok)
            next_state = WWD_CLOSED;
          else if (lead_end)
            next_state = WWD_RST;
        // closed window judges trig_valid, so a resistor fault cannot hide an early trigger
        WWD_CLOSED:
          if (trig_valid)
            next_state = WWD_RST;
          else if (clo_end)
            next_state = WWD_OPEN;
        WWD_OPEN:
          if (trig_ok)
            next_state = WWD_CLOSED;
          else if (open_end)
            next_state = WWD_RST;
        WWD_RST:
          if (ms_done)
            next_state = WWD_LEAD;
        WWD_OFF:
          next_state = WWD_POR;
        default:
          next_state = WWD_POR;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state     <= WWD_POR;
      tick_cnt  <= 13'h0000;
      ms_cnt    <= 18'h00000;
      strap_dis <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      tick_cnt <= (st_chg | ~count_st) ? 13'h0000 : (tick ? tick_cnt + 13'h0001 : tick_cnt);
      ms_cnt   <= (st_chg | ~timing_st) ? 18'h00000 : ms_cnt + 18'h00001;
      // the strap is looked at once, at the end of the startup hold
      if (state == WWD_POR && ms_done && !SLEEP_MODE)
        strap_dis <= strap_s;
      else if (SLEEP_MODE)
        strap_dis <= 1'b0;
    end
  end

  // ==========================================================
  // outputs
  // decoded from next_state so the pin moves on the same edge as the state
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      RESET_OUT_N <= 1'b0;
      WD_RUNNING  <= 1'b0;
    end
    else
    begin
      RESET_OUT_N <= ~next_low;
      WD_RUNNING  <= (next_state == WWD_LEAD) | (next_state == WWD_CLOSED) | (next_state == WWD_OPEN);
    end
  end

  // ==========================================================
  // checks
  wire quiet = ~SLEEP_MODE & ~wd_off;

  chk_closed_early: assert property (@(posedge CLK) disable iff (!rst_n)
    (state == WWD_CLOSED && trig_valid && quiet) |=> !RESET_OUT_N ##1 !RESET_OUT_N)
    else $error("early trigger did not reset");
  chk_lead_timeout: assert property (@(posedge CLK) disable iff (!rst_n)
    (state == WWD_LEAD && lead_end && !trig_ok && quiet) |=> state == WWD_RST && !RESET_OUT_N)
    else $error("lead time expiry missed");
  chk_open_timeout: assert property (@(posedge CLK) disable iff (!rst_n)
    (state == WWD_OPEN && open_end && !trig_ok && quiet) |=> !RESET_OUT_N)
    else $error("open window expiry missed");
  chk_open_trigger: assert property (@(posedge CLK) disable iff (!rst_n)
    (state == WWD_OPEN && trig_ok && quiet) |=> state == WWD_CLOSED && RESET_OUT_N && tick_cnt == 13'h0000)
    else $error("open window trigger not accepted");
  chk_lead_trigger: assert property (@(posedge CLK) disable iff (!rst_n)
    (state == WWD_LEAD && trig_ok && quiet) |=> state == WWD_CLOSED)
    else $error("lead trigger not accepted");
  chk_glitch_reject: assert property (@(posedge CLK) disable iff (!rst_n)
    trig_valid |-> !$past(trig_s, 1) && !$past(trig_s, 8))
    else $error("short low pulse accepted");
  // sleep or a disable may legally cut a pulse short
  chk_pulse_length: assert property (@(posedge CLK) disable iff (!rst_n)
    $rose(RESET_OUT_N) && !$past(SLEEP_MODE) && !$past(wd_off) |-> $past(ms_cnt) == RESET_CYC - 18'h00001)
    else $error("reset pulse length wrong");
  chk_sleep_quiet: assert property (@(posedge CLK) disable iff (!rst_n)
    SLEEP_MODE |=> !WD_RUNNING && tick_cnt == 13'h0000)
    else $error("watchdog active in sleep");
  chk_disable_double: assert property (@(posedge CLK) disable iff (!rst_n)
    $rose(WD_DISABLE_BIT) |-> $past(cfg_pend) && $past(CFG_WORD_STB))
    else $error("disable bit set by one word");
  chk_lp_gate: assert property (@(posedge CLK) disable iff (!rst_n)
    LOW_POWER_EN |-> $past(WD_DISABLE_BIT))
    else $error("low power without disable");
  chk_lp_refused: assert property (@(posedge CLK) disable iff (!rst_n)
    !WD_DISABLE_BIT |=> !LOW_POWER_EN)
    else $error("low power granted while watchdog enabled");
  chk_wake_lead: assert property (@(posedge CLK) disable iff (!rst_n)
    ((state == WWD_RST || state == WWD_POR) && ms_done && quiet && !strap_s) |=> state == WWD_LEAD && RESET_OUT_N)
    else $error("sequence did not restart from lead time");
  chk_lead_start: assert property (@(posedge CLK) disable iff (!rst_n)
    $rose(RESET_OUT_N) |-> tick_cnt == 13'h0000 && (state == WWD_LEAD || state == WWD_OFF))
    else $error("lead time not started at reset release");
  chk_strap_hold: assert property (@(posedge CLK) disable iff (!rst_n)
    (state == WWD_POR && ms_done && !SLEEP_MODE && strap_s) |=> state == WWD_OFF && RESET_OUT_N && strap_dis)
    else $error("strap did not disable watchdog");
  chk_fault_ignore: assert property (@(posedge CLK) disable iff (!rst_n)
    (fault_s && trig_valid && quiet && (state == WWD_LEAD || state == WWD_OPEN)) |=> state != WWD_CLOSED)
    else $error("trigger accepted with oscillator fault");
  chk_off_timers: assert property (@(posedge CLK) disable iff (!rst_n)
    state == WWD_OFF |-> ms_cnt == 18'h00000 && tick_cnt == 13'h0000)
    else $error("timers count while watchdog off");
  chk_sleep_high: assert property (@(posedge CLK) disable iff (!rst_n)
    SLEEP_MODE |=> RESET_OUT_N)
    else $error("reset output low in sleep");
  chk_low_once: assert property (@(posedge CLK) disable iff (!rst_n)
    trig_valid |=> !trig_valid)
    else $error("long low counted twice");

  // ==========================================================
  // cover points
  cov_lead_closed: cover property (@(posedge CLK) disable iff (!rst_n)
    state == WWD_LEAD ##1 state == WWD_CLOSED);
  cov_open_ok: cover property (@(posedge CLK) disable iff (!rst_n)
    state == WWD_OPEN ##1 state == WWD_CLOSED);
  cov_timeout: cover property (@(posedge CLK) disable iff (!rst_n)
    state == WWD_OPEN ##1 state == WWD_RST);
  cov_strap_off: cover property (@(posedge CLK) disable iff (!rst_n)
    state == WWD_POR ##1 state == WWD_OFF);
  cov_closed_early: cover property (@(posedge CLK) disable iff (!rst_n)
    state == WWD_CLOSED ##1 state == WWD_RST);

endmodule : wwd_top

// *** src/wwd_defines.svh ***
// timing and count constants of the window watchdog
`ifndef WWD_DEFINES_SVH
`define WWD_DEFINES_SVH
`define WWD_CLK_PERIOD_NS 25
`define WWD_TRIG_MIN_NS   7000
`define WWD_TRIG_MIN_CYC  ((`WWD_TRIG_MIN_NS + `WWD_CLK_PERIOD_NS - 1) / `WWD_CLK_PERIOD_NS)
`define WWD_RESET_MS      4
`define WWD_RESET_CYC     (`WWD_RESET_MS * 1000000 / `WWD_CLK_PERIOD_NS)
`define WWD_LEAD_TICKS    7895
`define WWD_CLOSED_TICKS  1053
`define WWD_OPEN_TICKS    1105
`define WWD_FS_DIV        800
`endif

// *** src/wwd_pkg.sv ***
// types of the window watchdog
package wwd_pkg;
  typedef enum logic [5:0] {
    WWD_POR    = 6'h01,
    WWD_LEAD   = 6'h02,
    WWD_CLOSED = 6'h04,
    WWD_OPEN   = 6'h08,
    WWD_RST    = 6'h10,
    WWD_OFF    = 6'h20
  } wwd_state_type;
endpackage : wwd_pkg

// *** dv/wwd_mcu_model.sv ***
// controller model that drives the watchdog trigger line
`timescale 1ns/100ps
module wwd_mcu_model (
  input  wire logic clk,
  output logic      trig_n
);
  initial trig_n = 1'b1;
  // ==========
  // trigger pulse, low for the given cycles, changed at falling edges
  task pulse(input int low_cyc);
    @(negedge clk);
    trig_n = 1'b0;
    repeat (low_cyc) @(negedge clk);
    trig_n = 1'b1;
  endtask : pulse
endmodule : wwd_mcu_model

// *** dv/test_window_watchdog_timer.sv ***
// self-checking bench of the window watchdog
`timescale 1ns/100ps
module test_window_watchdog_timer;
  typedef struct {int gap; int low; logic exp;} wwd_row_type;
  logic        clk, rst_b, osc, sleep, stb, cfg_d, lp, strap, fault;
  logic        trig_n, rst_out_n, dis_bit, lp_en, running;
  int          failures, check_count, n, i;
  // gap before pulse, low time, reset output afterwards; starts in lead time
  wwd_row_type rows [5] = '{'{40, 16, 1'b1}, '{55, 16, 1'b1}, '{10, 4, 1'b1}, '{30, 16, 1'b1}, '{10, 16, 1'b0}};

  // internal fail-safe tick keeps its default divider
  wwd_top #(.RESET_CYC(18'h32), .TRIG_MIN_CYC(9'ha), .LEAD_TICKS(13'h14), .CLOSED_TICKS(13'h6),
            .OPEN_TICKS(13'h8)) u_wwd_top (
    .CLK(clk), .RST_B(rst_b), .WD_TRIGGER_N(trig_n), .WD_OSC_RESISTOR_PIN(osc), .OSC_FAULT(fault),
    .DIVIDER_STRAP_PIN(strap), .SLEEP_MODE(sleep), .CFG_WORD_STB(stb), .CFG_WD_DISABLE(cfg_d),
    .LP_REQUEST(lp), .RESET_OUT_N(rst_out_n), .WD_DISABLE_BIT(dis_bit), .LOW_POWER_EN(lp_en),
    .WD_RUNNING(running));
  wwd_mcu_model u_wwd_mcu_model (.clk(clk), .trig_n(trig_n));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // oscillator tick every 8 clocks, so lead is about 160 clocks
  always
  begin
    repeat (4) @(negedge clk);
    osc = ~osc;
  end

  // ==========
  // shared tasks
  task chk(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // n returns the clocks waited for the reset output to reach v
  task wait_rst(input logic v, input int lim);
    n = 0;
    while (rst_out_n !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= lim)
    begin
      failures++;
      $display("Error reset wait expected %b seen timeout", v);
      tally_and_finish();
    end
  endtask : wait_rst
  task cfg(input logic v);
    stb = 1'b1;
    cfg_d = v;
    @(negedge clk);
    stb = 1'b0;
    @(negedge clk);
  endtask : cfg

  // ==========
  // main sequence
  initial
  begin
    {rst_b, osc, sleep, stb, cfg_d, lp, strap, fault} = 8'h00;
    failures = 0;
    check_count = 0;
    repeat (4) @(negedge clk);
    chk("reset out in reset", 1'b0, rst_out_n);
    chk("running in reset", 1'b0, running);
    rst_b = 1'b1;
    wait_rst(1'b1, 80);
    chk("startup hold length", 1'b1, n >= 48);
    for (i = 0; i < 5; i++)
    begin
      repeat (rows[i].gap) @(negedge clk);
      u_wwd_mcu_model.pulse(rows[i].low);
      repeat (6) @(negedge clk);
      chk("reset out after trigger", rows[i].exp, rst_out_n);
    end
    wait_rst(1'b1, 80);
    chk("pulse after early trigger", 1'b1, n >= 35);
    wait_rst(1'b0, 200);
    chk("lead time length", 1'b1, n >= 150);
    wait_rst(1'b1, 80);
    chk("lead expiry pulse", 1'b1, n >= 48);
    u_wwd_mcu_model.pulse(16);
    wait_rst(1'b0, 160);
    chk("open window expiry", 1'b1, n >= 90 && n <= 125);
    wait_rst(1'b1, 80);
    lp = 1'b1;
    cfg(1'b1);
    cfg(1'b0);
    cfg(1'b1);
    chk("disable after split words", 1'b0, dis_bit);
    chk("low power refused", 1'b0, lp_en);
    cfg(1'b1);
    chk("disable after two words", 1'b1, dis_bit);
    @(negedge clk);
    chk("low power allowed", 1'b1, lp_en);
    chk("watchdog stopped", 1'b0, running);
    cfg(1'b0);
    chk("disable cleared", 1'b0, dis_bit);
    sleep = 1'b1;
    repeat (3) @(negedge clk);
    n = 0;
    repeat (300)
    begin
      @(negedge clk);
      if (rst_out_n !== 1'b1 || running !== 1'b0)
        n++;
    end
    chk("quiet in sleep", 1'b1, n == 0);
    sleep = 1'b0;
    wait_rst(1'b0, 10);
    wait_rst(1'b1, 80);
    chk("hold after wake", 1'b1, n >= 45);
    wait_rst(1'b0, 200);
    chk("lead from wake edge", 1'b1, n >= 150);
    strap = 1'b1;
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    wait_rst(1'b1, 80);
    repeat (250) @(negedge clk);
    chk("strap keeps reset high", 1'b1, rst_out_n);
    chk("strap stops running", 1'b0, running);
    // resistor fault: internal tick of 800 clocks, trigger must be ignored
    strap = 1'b0;
    fault = 1'b1;
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    wait_rst(1'b1, 80);
    u_wwd_mcu_model.pulse(16);
    wait_rst(1'b0, 16100);
    chk("fault ignores trigger", 1'b1, n >= 15100 && n <= 16000);
    wait_rst(1'b1, 80);
    chk("fault reset pulse", 1'b1, n >= 48);
    tally_and_finish();
  end
endmodule : test_window_watchdog_timer
